// *** rtl/uid_defines.vh ***
// Purpose: constants for the uart interrupt and dma request block
// Assumes: 32-bit apb, byte addresses, one aligned word per register
// Notes: included by uid_ctrl.v and by the testbench
`ifndef UID_DEFINES_VH
`define UID_DEFINES_VH

// register byte offsets
`define UID_OFF_DATA 8'h00
`define UID_OFF_IER 8'h04
`define UID_OFF_FIFO_CONTROL_REG 8'h08
`define UID_OFF_LSR 8'h0c
`define UID_OFF_MSR 8'h10
`define UID_OFF_CTRL 8'h14
`define UID_OFF_LEVEL 8'h18
`define UID_OFF_BAUD 8'h1c

// irq_enable_reg fields
`define UID_IER_RDA 0
`define UID_IER_TX_HOLD_EMPTY 1
`define UID_IER_RLS 2
`define UID_IER_MS 3
`define UID_IER_TX_THRESHOLD_MODE_EN 7
`define UID_IER_RST 8'h00

// fifo_control_reg fields
`define UID_FCR_FIFOE 0
`define UID_FCR_RXRST 1
`define UID_FCR_TXRST 2
`define UID_FCR_TET_LO 4
`define UID_FCR_RT_LO 6
`define UID_FCR_RST 8'h00

// ctrl register fields
`define UID_CTRL_AFCE 0
`define UID_CTRL_RST 8'h00

// baud divisor reset value
`define UID_BAUD_RST 16'h0001

// irq_identity_reg source codes
`define UID_IID_RLS 4'h6
`define UID_IID_RDA 4'h4
`define UID_IID_CTO 4'hc
`define UID_IID_TX_HOLD_EMPTY 4'h2
`define UID_IID_MS 4'h0
`define UID_IID_NONE 4'h1

// decoded tx empty-trigger watermarks
`define UID_TET_L0 8'h00
`define UID_TET_L1 8'h10
`define UID_TET_L2 8'h20
`define UID_TET_L3 8'h40

// decoded rx trigger watermarks
`define UID_RT_L0 8'h01
`define UID_RT_L1 8'h20
`define UID_RT_L2 8'h40
`define UID_RT_L3 8'h7e

// character timing
`define UID_BIT_TICKS 16
`define UID_CHAR_BITS 10
`define UID_TO_CHARS 4

`endif

// *** rtl/uid_ctrl.v ***
// Purpose: interrupt prioritisation, fifo watermarks and dma requests of a uart
// Assumes: pclk 25 MHz, presetn released by the reset manager once software frees it
// Notes: serial framing lives outside; it pushes received characters and takes tx characters
// Contract
// - line status irq: errors, cleared by lsr read
// - rx data irq at trigger or any char
// - timeout after four idle character times
// - tx_hold_empty irq: empty or at/below threshold
// - tx_hold_empty cleared by iir read, write, level
// - modem irq on input changes, msr read clears
// - no cts irq while auto flow control
// - irq when any enabled source active
// - rx data and timeout share enable
// - identity register reports pending source
// - threshold mode drives tx_hold_empty and tx dma; here tx dma follows the watermark in both modes
// - four tx empty-trigger thresholds
// - empty-trigger value one means sixteen entries
// - threshold mode: lsr empty flag shows full
// - normal mode: flags show empty transmitter
// - separate tx/rx dma, single and burst
// - tx dma when level at/below watermark
// - empty tx fifo leaves line idle
// - held in reset until software release
// - rx dma when level at/above trigger
// - one bit time is sixteen baud ticks
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "uid_defines.vh"

module uid_ctrl #(
    parameter DEPTH = 128,
    parameter AW = 7
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire rx_push,
    input wire [7:0] rx_data,
    input wire rx_parity_err,
    input wire rx_frame_err,
    input wire rx_break,
    input wire tx_take,
    output reg tx_valid,
    output reg [7:0] tx_data,
    input wire cts_n,
    input wire dsr_n,
    input wire ri_n,
    input wire dcd_n,
    output reg irq,
    output reg dma_tx_req,
    output reg dma_tx_single,
    output reg dma_rx_req,
    output reg dma_rx_single
);

    localparam [11:0] TO_TICKS = `UID_BIT_TICKS * `UID_CHAR_BITS * `UID_TO_CHARS;
    localparam [AW:0] DEPTH_C = DEPTH;

    reg [7:0] tx_mem [0:DEPTH-1];
    reg [7:0] rx_mem [0:DEPTH-1];
    reg [AW-1:0] tx_wr_reg, tx_rd_reg, rx_wr_reg, rx_rd_reg;
    reg [AW:0] tx_cnt_reg, rx_cnt_reg;
    reg [7:0] irq_enable_reg, fifo_control_reg, ctrl_reg;
    reg [15:0] baud_reg, div_cnt_reg;
    reg [11:0] to_cnt_reg;
    reg baud_tick_reg;
    reg ovr_reg, par_reg, frm_reg, brk_reg;
    reg to_flag_reg, tx_hold_empty_pend_reg, tx_hold_empty_cond_prev_reg;
    reg [3:0] ms_s1_reg, ms_s2_reg, ms_prev_reg, ms_delta_reg;
    reg rd_ok_reg, iir_tx_hold_empty_src_reg;
    reg [3:0] iid;
    reg [31:0] rdata;
    reg addr_ok;

    wire fifo_en = fifo_control_reg[`UID_FCR_FIFOE];
    wire afce_on = ctrl_reg[`UID_CTRL_AFCE] & fifo_en;
    wire thr_mode = irq_enable_reg[`UID_IER_TX_THRESHOLD_MODE_EN] & fifo_en;
    // with fifos off the buffers behave as single holding registers
    wire [AW:0] cap = fifo_en ? DEPTH_C : {{AW{1'b0}}, 1'b1};
    wire tx_full = (tx_cnt_reg >= cap);
    wire rx_full = (rx_cnt_reg >= cap);
    wire setup = psel & ~penable;
    wire acc = psel & penable & pready;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire wr_fcr = wr & (paddr == `UID_OFF_FIFO_CONTROL_REG);
    wire tx_flush = wr_fcr & (pwdata[`UID_FCR_TXRST] | (pwdata[`UID_FCR_FIFOE] != fifo_en));
    wire rx_flush = wr_fcr & (pwdata[`UID_FCR_RXRST] | (pwdata[`UID_FCR_FIFOE] != fifo_en));
    wire tx_push = wr & (paddr == `UID_OFF_DATA) & ~tx_full;
    wire tx_pop = tx_take & tx_valid;
    wire rx_pop = rd & (paddr == `UID_OFF_DATA) & rd_ok_reg;
    wire rx_in = rx_push & ~rx_full;
    wire lsr_rd = rd & (paddr == `UID_OFF_LSR);
    wire msr_rd = rd & (paddr == `UID_OFF_MSR);
    wire iir_rd = rd & (paddr == `UID_OFF_FIFO_CONTROL_REG);
    wire to_restart = rx_in | rx_pop | rx_flush | (rx_cnt_reg == 0) | ~fifo_en;

    reg [7:0] tet_lvl, rt_lvl;
    always @* begin
        case (fifo_control_reg[`UID_FCR_TET_LO +: 2])
            2'd0: tet_lvl = `UID_TET_L0;
            2'd1: tet_lvl = `UID_TET_L1;
            2'd2: tet_lvl = `UID_TET_L2;
            default: tet_lvl = `UID_TET_L3;
        endcase
        case (fifo_control_reg[`UID_FCR_RT_LO +: 2])
            2'd0: rt_lvl = `UID_RT_L0;
            2'd1: rt_lvl = `UID_RT_L1;
            2'd2: rt_lvl = `UID_RT_L2;
            default: rt_lvl = `UID_RT_L3;
        endcase
    end

    wire tx_at_wm = ({1'b0, tx_cnt_reg} <= {1'b0, tet_lvl});
    wire rx_at_rt = ({1'b0, rx_cnt_reg} >= {1'b0, rt_lvl});
    // threshold mode swaps the meaning of the tx_hold_empty condition
    wire tx_hold_empty_cond = thr_mode ? tx_at_wm : (tx_cnt_reg == 0);
    wire rls_act = ovr_reg | par_reg | frm_reg | brk_reg;
    wire rda_act = fifo_en ? rx_at_rt : (rx_cnt_reg != 0);
    wire ms_act = |ms_delta_reg[3:1] | (ms_delta_reg[0] & ~afce_on);

    always @* begin
        if (irq_enable_reg[`UID_IER_RLS] & rls_act) begin
            iid = `UID_IID_RLS;
        end else if (irq_enable_reg[`UID_IER_RDA] & rda_act) begin
            iid = `UID_IID_RDA;
        end else if (irq_enable_reg[`UID_IER_RDA] & to_flag_reg) begin
            iid = `UID_IID_CTO;
        end else if (irq_enable_reg[`UID_IER_TX_HOLD_EMPTY] & tx_hold_empty_pend_reg) begin
            iid = `UID_IID_TX_HOLD_EMPTY;
        end else if (irq_enable_reg[`UID_IER_MS] & ms_act) begin
            iid = `UID_IID_MS;
        end else begin
            iid = `UID_IID_NONE;
        end
    end

    always @* begin
        rdata = 32'h0000_0000;
        addr_ok = 1'b1;
        if (paddr == `UID_OFF_DATA) begin
            rdata[7:0] = rx_mem[rx_rd_reg];
        end else if (paddr == `UID_OFF_IER) begin
            rdata[7:0] = irq_enable_reg;
        end else if (paddr == `UID_OFF_FIFO_CONTROL_REG) begin
            rdata[7:0] = {fifo_en, fifo_en, 2'b00, iid};
        end else if (paddr == `UID_OFF_LSR) begin
            rdata[0] = (rx_cnt_reg != 0);
            rdata[1] = ovr_reg;
            rdata[2] = par_reg;
            rdata[3] = frm_reg;
            rdata[4] = brk_reg;
            rdata[5] = thr_mode ? tx_full : (tx_cnt_reg == 0);
            rdata[6] = (tx_cnt_reg == 0);
        end else if (paddr == `UID_OFF_MSR) begin
            rdata[7:0] = {~ms_s2_reg, ms_delta_reg};
        end else if (paddr == `UID_OFF_CTRL) begin
            rdata[7:0] = ctrl_reg;
        end else if (paddr == `UID_OFF_LEVEL) begin
            rdata[AW:0] = tx_cnt_reg;
            rdata[16+AW:16] = rx_cnt_reg;
        end else if (paddr == `UID_OFF_BAUD) begin
            rdata[15:0] = baud_reg;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // storage arrays carry no reset; counters define what is valid
    always @(posedge pclk) begin
        if (tx_push) begin
            tx_mem[tx_wr_reg] <= pwdata[7:0];
        end
        if (rx_in) begin
            rx_mem[rx_wr_reg] <= rx_data;
        end
    end

    // presetn is the reset manager's hold, released only by software
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            rd_ok_reg <= 1'b0;
            iir_tx_hold_empty_src_reg <= 1'b0;
            irq_enable_reg <= `UID_IER_RST;
            fifo_control_reg <= `UID_FCR_RST;
            ctrl_reg <= `UID_CTRL_RST;
            baud_reg <= `UID_BAUD_RST;
        end else begin
            // no wait state: data is captured in setup, answered in the first access cycle
            pready <= setup;
            pslverr <= setup & ~addr_ok;
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : rdata;
                rd_ok_reg <= (rx_cnt_reg != 0);
                iir_tx_hold_empty_src_reg <= (iid == `UID_IID_TX_HOLD_EMPTY);
            end
            if (wr & (paddr == `UID_OFF_IER)) begin
                irq_enable_reg <= {pwdata[7], 3'b000, pwdata[3:0]};
            end
            if (wr_fcr) begin
                fifo_control_reg <= {pwdata[7:4], 3'b000, pwdata[`UID_FCR_FIFOE]};
            end
            if (wr & (paddr == `UID_OFF_CTRL)) begin
                ctrl_reg <= {7'h00, pwdata[`UID_CTRL_AFCE]};
            end
            if (wr & (paddr == `UID_OFF_BAUD)) begin
                baud_reg <= pwdata[15:0];
            end
        end
    end

    // fifo pointers and counts; depth fixed by DEPTH
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_wr_reg <= {AW{1'b0}};
            tx_rd_reg <= {AW{1'b0}};
            tx_cnt_reg <= {(AW+1){1'b0}};
            rx_wr_reg <= {AW{1'b0}};
            rx_rd_reg <= {AW{1'b0}};
            rx_cnt_reg <= {(AW+1){1'b0}};
        end else begin
            if (tx_flush) begin
                tx_wr_reg <= {AW{1'b0}};
                tx_rd_reg <= {AW{1'b0}};
                tx_cnt_reg <= {(AW+1){1'b0}};
            end else begin
                if (tx_push) begin
                    tx_wr_reg <= tx_wr_reg + 1'b1;
                end
                if (tx_pop) begin
                    tx_rd_reg <= tx_rd_reg + 1'b1;
                end
                if (tx_push & ~tx_pop) begin
                    tx_cnt_reg <= tx_cnt_reg + 1'b1;
                end else if (tx_pop & ~tx_push) begin
                    tx_cnt_reg <= tx_cnt_reg - 1'b1;
                end
            end
            if (rx_flush) begin
                rx_wr_reg <= {AW{1'b0}};
                rx_rd_reg <= {AW{1'b0}};
                rx_cnt_reg <= {(AW+1){1'b0}};
            end else begin
                if (rx_in) begin
                    rx_wr_reg <= rx_wr_reg + 1'b1;
                end
                if (rx_pop) begin
                    rx_rd_reg <= rx_rd_reg + 1'b1;
                end
                if (rx_in & ~rx_pop) begin
                    rx_cnt_reg <= rx_cnt_reg + 1'b1;
                end else if (rx_pop & ~rx_in) begin
                    rx_cnt_reg <= rx_cnt_reg - 1'b1;
                end
            end
        end
    end

    // baud tick divider and character timeout counter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= 16'h0000;
            baud_tick_reg <= 1'b0;
            to_cnt_reg <= 12'h000;
            to_flag_reg <= 1'b0;
        end else begin
            if (div_cnt_reg + 16'h0001 >= baud_reg) begin
                div_cnt_reg <= 16'h0000;
                baud_tick_reg <= 1'b1;
            end else begin
                div_cnt_reg <= div_cnt_reg + 16'h0001;
                baud_tick_reg <= 1'b0;
            end
            // any accepted rx push, read or flush, an empty rx fifo or fifos off restarts the idle measurement
            if (to_restart) begin
                to_cnt_reg <= 12'h000;
            end else if (baud_tick_reg & (to_cnt_reg != TO_TICKS)) begin
                to_cnt_reg <= to_cnt_reg + 12'h001;
            end
            // set only on the step into the limit, so a buffer read can clear it
            if (~to_restart & baud_tick_reg & (to_cnt_reg == TO_TICKS - 12'h001)) begin
                to_flag_reg <= 1'b1;
            end else if (rx_pop | rx_flush) begin
                to_flag_reg <= 1'b0;
            end
        end
    end

    // sticky line errors; an event in the clearing cycle wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr_reg <= 1'b0;
            par_reg <= 1'b0;
            frm_reg <= 1'b0;
            brk_reg <= 1'b0;
        end else begin
            ovr_reg <= (rx_push & rx_full) | (ovr_reg & ~lsr_rd);
            par_reg <= (rx_push & rx_parity_err) | (par_reg & ~lsr_rd);
            frm_reg <= (rx_push & rx_frame_err) | (frm_reg & ~lsr_rd);
            brk_reg <= rx_break | (brk_reg & ~lsr_rd);
        end
    end

    // modem inputs cross from the pins through two flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_s1_reg <= 4'hf;
            ms_s2_reg <= 4'hf;
            ms_prev_reg <= 4'hf;
            ms_delta_reg <= 4'h0;
        end else begin
            ms_s1_reg <= {dcd_n, ri_n, dsr_n, cts_n};
            ms_s2_reg <= ms_s1_reg;
            ms_prev_reg <= ms_s2_reg;
            ms_delta_reg <= (ms_s2_reg ^ ms_prev_reg) | (ms_delta_reg & {4{~msr_rd}});
        end
    end

    // tx_hold_empty pending flag fires on the rising edge of its condition
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_hold_empty_cond_prev_reg <= 1'b0;
            tx_hold_empty_pend_reg <= 1'b0;
        end else begin
            tx_hold_empty_cond_prev_reg <= tx_hold_empty_cond;
            if (tx_hold_empty_cond & ~tx_hold_empty_cond_prev_reg) begin
                tx_hold_empty_pend_reg <= 1'b1;
            end else if ((iir_rd & iir_tx_hold_empty_src_reg) | (~thr_mode & tx_push) | (thr_mode & ~tx_hold_empty_cond)) begin
                tx_hold_empty_pend_reg <= 1'b0;
            end
        end
    end

    // registered outputs toward serializer, dma and interrupt controller
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            irq <= 1'b0;
            dma_tx_req <= 1'b0;
            dma_tx_single <= 1'b0;
            dma_rx_req <= 1'b0;
            dma_rx_single <= 1'b0;
        end else begin
            // an empty fifo drops valid, so the serializer idles in stop state
            tx_valid <= (tx_cnt_reg != 0) & ~tx_pop & ~tx_flush & ~(afce_on & ms_s2_reg[0]);
            tx_data <= tx_mem[tx_rd_reg];
            irq <= (iid != `UID_IID_NONE);
            dma_tx_req <= tx_at_wm;
            dma_tx_single <= ~tx_full;
            dma_rx_req <= fifo_en ? rx_at_rt : (rx_cnt_reg != 0);
            dma_rx_single <= (rx_cnt_reg != 0);
        end
    end

endmodule

// *** verification/uid_ctrl_asserts.sv ***
// Purpose: port-level assertions for uid_ctrl
// Assumes: one pclk domain, presetn asynchronous and active low
// Notes: irq and dma levels may only fall shortly after a bus access or a received character
`timescale 1ns/1ps
module uid_ctrl_asserts (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire rx_push,
    input wire tx_take,
    input wire tx_valid,
    input wire irq,
    input wire dma_tx_req,
    input wire dma_tx_single,
    input wire dma_rx_req,
    input wire dma_rx_single
);
    reg [2:0] age_reg;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // saturating age since the last access or character, so a clear can be traced to its cause
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_reg <= 3'h7;
        end else if ((psel && penable && pready) || rx_push) begin
            age_reg <= 3'h0;
        end else if (age_reg != 3'h7) begin
            age_reg <= age_reg + 3'h1;
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        psel && penable && pready;
    endsequence
    property p_apb_answer;
        s_setup |=> s_answer;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("no ready in first access cycle");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_reset_out;
        $rose(presetn) |=> dma_tx_req && dma_tx_single && !irq && !tx_valid;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("wrong outputs after reset");
    property p_take_drop;
        tx_valid && tx_take |=> !tx_valid;
    endproperty
    a_take_drop: assert property (p_take_drop) else $error("tx valid held after take");
    property p_irq_fall;
        $fell(irq) |-> age_reg <= 3'h3;
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without clearing action");
    property p_rx_fall;
        $fell(dma_rx_req) |-> age_reg <= 3'h3;
    endproperty
    a_rx_fall: assert property (p_rx_fall) else $error("rx request fell without read");
    property p_tx_fall;
        $fell(dma_tx_req) |-> age_reg <= 3'h3;
    endproperty
    a_tx_fall: assert property (p_tx_fall) else $error("tx request fell without write");
    property p_rx_single;
        dma_rx_req |-> dma_rx_single;
    endproperty
    a_rx_single: assert property (p_rx_single) else $error("rx burst request while empty");
    property p_tx_single;
        dma_tx_req |-> dma_tx_single;
    endproperty
    a_tx_single: assert property (p_tx_single) else $error("tx burst request while full");
    property p_push_single;
        rx_push && !psel |-> ##[1:3] dma_rx_single;
    endproperty
    a_push_single: assert property (p_push_single) else $error("received char not seen");
endmodule

bind uid_ctrl uid_ctrl_asserts chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .rx_push(rx_push), .tx_take(tx_take), .tx_valid(tx_valid),
    .irq(irq), .dma_tx_req(dma_tx_req), .dma_tx_single(dma_tx_single), .dma_rx_req(dma_rx_req),
    .dma_rx_single(dma_rx_single));

// *** verification/uid_far_model.sv ***
// Purpose: far-side model: character taker and dma burst sizing
// Assumes: a take pulse is sampled together with tx_valid at the next edge
// Notes: slow mode spaces the takes so the head register is held for a while
`timescale 1ns/1ps
module uid_far_model (
    input wire pclk,
    input wire presetn,
    input wire tx_valid,
    input wire slow,
    input wire [1:0] tx_empty_trigger,
    output reg tx_take,
    output wire [7:0] burst_len
);
    reg [1:0] gap_reg;
    // burst equals the free space at the moment the request fires
    assign burst_len = 8'h80 - ((tx_empty_trigger == 2'h0) ? 8'h00 : (8'h08 << tx_empty_trigger));
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_take <= 1'b0;
            gap_reg <= 2'h0;
        end else begin
            gap_reg <= gap_reg + 2'h1;
            tx_take <= tx_valid && !tx_take && (!slow || gap_reg == 2'h0);
        end
    end
endmodule

// *** verification/tb_top.sv ***
// Purpose: self-checking bench for uid_ctrl
// Assumes: register map, decodes and latencies as handed over by the designer
// Notes: read results go through a queue; levels are compared a few cycles after their cause
`timescale 1ns/1ps
`include "uid_defines.vh"
module tb_top;
    reg pclk = 0;
    reg presetn = 0;
    reg psel = 0;
    reg penable = 0;
    reg pwrite = 0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg rx_push = 0, pe = 0, fe = 0, brk = 0, cts_n = 1, dsr_n = 1, slow = 0;
    reg [7:0] rx_data = 8'h00;
    reg [7:0] c;
    reg [1:0] tx_empty_trigger = 2'h0;
    wire [31:0] prdata;
    wire [7:0] tx_data, blen;
    wire pready, pslverr, tx_take, tx_valid, irq, dtr, dts, drr, drs;
    integer miscompares = 0;
    integer num_checks = 0;
    integer i, k, wm;
    reg [65:0] rq[$];
    reg [7:0] tq[$];

    always #20 pclk = ~pclk;

    uid_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_push(rx_push), .rx_data(rx_data), .rx_parity_err(pe), .rx_frame_err(fe), .rx_break(brk),
        .tx_take(tx_take), .tx_valid(tx_valid), .tx_data(tx_data), .cts_n(cts_n), .dsr_n(dsr_n),
        .ri_n(1'b1), .dcd_n(1'b1), .irq(irq), .dma_tx_req(dtr), .dma_tx_single(dts),
        .dma_rx_req(drr), .dma_rx_single(drs));
    uid_far_model far (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .slow(slow), .tx_empty_trigger(tx_empty_trigger),
        .tx_take(tx_take), .burst_len(blen));

    task ckw(input [32:0] e, input [32:0] a, input [32:0] m);
        num_checks = num_checks + 1;
        if ((a & m) !== e) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t exp %h got %h", $time, e, a & m);
        end
    endtask
    task ckb(input e, input a);
        ckw({32'h0, e}, {32'h0, a}, 33'h1);
    endtask
    task tally_and_finish;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task apb(input w, input [7:0] a, input [31:0] d, input [32:0] e, input [32:0] m);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) rq.push_back({m, e});
        @(posedge pclk);
        penable <= 1;
        // no local limit: the watchdog ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        apb(1, a, d, 0, 0);
    endtask
    task rd(input [7:0] a, input [32:0] e);
        apb(0, a, 0, e, {33{1'b1}});
    endtask
    task push(input [7:0] d, input p, input f, input b);
        @(posedge pclk);
        rx_push <= !b;
        rx_data <= d;
        pe <= p;
        fe <= f;
        brk <= b;
        @(posedge pclk);
        rx_push <= 0;
        brk <= 0;
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0) begin
            ckw(rq[0][32:0], {pslverr, prdata}, rq[0][65:33]);
            void'(rq.pop_front());
        end
        if (tx_valid === 1'b1 && tx_take && tq.size() > 0) begin
            ckw({25'h0, tq[0]}, {25'h0, tx_data}, 33'hff);
            void'(tq.pop_front());
        end
    end

    initial begin
        i = $urandom(13069);
        repeat (8) @(posedge pclk);
        presetn <= 1;
        rd(`UID_OFF_IER, {25'h0, `UID_IER_RST});
        rd(`UID_OFF_LSR, 33'h60);
        rd(`UID_OFF_BAUD, 33'h1);
        rd(8'h20, 33'h1_0000_0000);
        wr(`UID_OFF_CTRL, 32'h1);
        wr(`UID_OFF_IER, 32'h80);
        // cts_n stays high with auto flow on, so the tx fifo is not drained here
        for (k = 0; k < 4; k = k + 1) begin
            tx_empty_trigger <= k;
            wm = (k == 0) ? 0 : (8 << k);
            wr(`UID_OFF_FIFO_CONTROL_REG, (k << 4) | 5);
            for (i = 0; i < wm; i = i + 1) wr(`UID_OFF_DATA, $urandom % 256);
            cyc(3);
            ckb(1, dtr);
            wr(`UID_OFF_DATA, $urandom % 256);
            cyc(3);
            ckb(0, dtr);
            // the burst after the request fills exactly the free space
            for (i = 1; i < blen; i = i + 1) wr(`UID_OFF_DATA, $urandom % 256);
            rd(`UID_OFF_LEVEL, wm + blen);
            if (k == 0) begin
                rd(`UID_OFF_LSR, 33'h20);
                ckb(0, dts);
            end
        end
        wr(`UID_OFF_IER, 32'h2);
        wr(`UID_OFF_FIFO_CONTROL_REG, 32'h7);
        cyc(4);
        ckb(1, irq);
        rd(`UID_OFF_FIFO_CONTROL_REG, 33'hc2);
        cyc(3);
        ckb(0, irq);
        wr(`UID_OFF_IER, 32'h5);
        c = $urandom % 256;
        push(c, 0, 0, 0);
        cyc(3);
        ckb(1, drr);
        ckb(1, drs);
        rd(`UID_OFF_FIFO_CONTROL_REG, 33'hc4);
        // overrun, parity, framing, break in turn on a freshly flushed rx fifo
        for (k = 1; k < 5; k = k + 1) begin
            wr(`UID_OFF_FIFO_CONTROL_REG, 32'h3);
            if (k == 1) begin
                for (i = 0; i < 129; i = i + 1) push(i, 0, 0, 0);
                rd(`UID_OFF_LEVEL, 33'h80_0000);
            end else push(c, k == 2, k == 3, k == 4);
            rd(`UID_OFF_FIFO_CONTROL_REG, 33'hc6);
            apb(0, `UID_OFF_LSR, 0, 33'h1 << k, 33'h1 << k);
            rd(`UID_OFF_FIFO_CONTROL_REG, (k == 4) ? 33'hc1 : 33'hc4);
        end
        wr(`UID_OFF_FIFO_CONTROL_REG, 32'h3);
        push(c, 0, 0, 0);
        push(c ^ 8'h5a, 0, 0, 0);
        rd(`UID_OFF_DATA, c);
        rd(`UID_OFF_DATA, c ^ 8'h5a);
        cyc(3);
        ckb(0, irq);
        ckb(0, drr);
        ckb(0, drs);
        wr(`UID_OFF_FIFO_CONTROL_REG, 32'h41);
        push(c, 0, 0, 0);
        cyc(600);
        ckb(0, irq);
        cyc(100);
        ckb(1, irq);
        rd(`UID_OFF_FIFO_CONTROL_REG, 33'hcc);
        rd(`UID_OFF_DATA, c);
        cyc(3);
        ckb(0, irq);
        wr(`UID_OFF_IER, 32'h8);
        cts_n <= 0;
        cyc(8);
        ckb(0, irq);
        rd(`UID_OFF_MSR, 33'h11);
        dsr_n <= 0;
        cyc(8);
        ckb(1, irq);
        rd(`UID_OFF_FIFO_CONTROL_REG, 33'hc0);
        rd(`UID_OFF_MSR, 33'h32);
        cyc(3);
        ckb(0, irq);
        slow <= 1;
        for (i = 0; i < 4; i = i + 1) begin
            c = $urandom % 256;
            tq.push_back(c);
            wr(`UID_OFF_DATA, c);
        end
        cyc(40);
        ckb(0, tx_valid);
        ckb(1, tq.size() == 0);
        tally_and_finish;
    end

    initial begin
        #800000;
        miscompares = miscompares + 1;
        tally_and_finish;
    end
endmodule
